//--- fss_pkg.sv
/*
 * Shared constants and types for the fan and sensor status register bank.
 * Assumes a 32-bit APB slave with byte addresses of four times the register index.
 */
`default_nettype none

package fss_pkg;

	// ************************************************************
	// register indices (byte address = index * 4)
	// ************************************************************
	localparam logic [5:0] IDX_SUMMARY   = 6'h00;
	localparam logic [5:0] IDX_SENSORS   = 6'h06;
	localparam logic [5:0] IDX_FAN_ONE   = 6'h10;
	localparam logic [5:0] IDX_FAN_TWO   = 6'h11;
	localparam logic [5:0] IDX_ACT_ONE   = 6'h18;
	localparam logic [5:0] IDX_ACT_TWO   = 6'h19;
	localparam logic [5:0] IDX_INT_STAT  = 6'h20;
	localparam logic [5:0] IDX_INT_MASK  = 6'h21;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int B_MISSING    = 0;
	localparam int B_MISSING_L  = 1;
	localparam int B_FAULT      = 2;
	localparam int B_FAULT_L    = 3;
	localparam int B_SLEEP      = 4;
	localparam int B_HP_PRIO    = 5;
	localparam int B_TACH_L     = 6;
	localparam int B_HOTPLUG_L  = 7;
	localparam int B_SUMMARY_HP = 6;
	localparam int B_ACT_SLEEP_ALARM = 4;
	localparam int B_LOCAL      = 0;
	localparam int B_REMOTE_ONE = 1;
	localparam int B_REMOTE_TWO = 2;

	// interrupt status layout: [1:0] removal, [3:2] insertion, [5:4] fault, [7:6] tach
	localparam int INT_RM  = 0;
	localparam int INT_IN  = 2;
	localparam int INT_FLT = 4;
	localparam int INT_TCH = 6;

	// ************************************************************
	// reset values and timing
	// ************************************************************
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;
	localparam logic [1:0]  RST_PIN_HI  = 2'h3;
	localparam logic [1:0]  PRIME_LAST  = 2'h3;

	typedef enum logic [3:0] {
		FM_NORMAL  = 4'h1,
		FM_ALARM   = 4'h2,
		FM_HOTPLUG = 4'h4,
		FM_STOP    = 4'h8
	} fss_mode_t;

	typedef struct packed {
		logic [1:0] present_n;
		logic [1:0] fault_n;
		logic [1:0] remote_det;
	} fss_pins_t;

	typedef struct packed {
		logic [1:0] tach_fault;
		logic [1:0] overtemp;
	} fss_evt_t;

	typedef struct packed {
		fss_mode_t [1:0] mode;
		logic            summary_hp;
	} fss_ctl_t;

endpackage

`default_nettype wire

//--- fss_status_regs.sv
/*
 * Fan and sensor status register bank with APB slave, sticky interrupt status and fan mode select.
 * Assumes pins arrive asynchronously; tach fault and overtemp requests come from sys_clk logic.
 */
`timescale 1ns/10ps
`default_nettype none

module fss_status_regs (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic      [31:0]       prdata,
	output logic                   pslverr,
	// fan pins and sensor detection
	input  wire fss_pkg::fss_pins_t pins,
	// same-clock events
	input  wire fss_pkg::fss_evt_t evt,
	// fan control and interrupt
	output var fss_pkg::fss_ctl_t  ctl,
	output logic                   irq
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [1:0]          s1_pres;
		logic [1:0]          s2_pres;
		logic [1:0]          s1_flt;
		logic [1:0]          s2_flt;
		logic [1:0]          s1_rs;
		logic [1:0]          s2_rs;
		logic [1:0]          prev_pres;
		logic [1:0]          prev_flt;
		logic [1:0]          prime_cnt;
		logic                primed;
		logic [1:0]          remote_det;
		logic [1:0]          miss_l;
		logic [1:0]          flt_l;
		logic [1:0]          tach_l;
		logic [1:0]          hot_l;
		logic [1:0]          sleep;
		logic [1:0]          hp_prio;
		logic [1:0]          act_sleep_alarm;
		logic [7:0]          int_stat;
		logic [7:0]          int_mask;
		logic [31:0]         rdata;
		fss_pkg::fss_mode_t [1:0] mode;
	} fss_state_t;

	fss_state_t st_r;
	fss_state_t st_nxt;

	function automatic logic [5:0] reg_index(input logic [7:0] a);
		reg_index = a[7:2];
	endfunction

	function automatic logic reg_mapped(input logic [7:0] a);
		logic [5:0] i;
		i = a[7:2];
		reg_mapped = (a[1:0] == 2'h0) &&
			(i == fss_pkg::IDX_SUMMARY || i == fss_pkg::IDX_SENSORS ||
			 i == fss_pkg::IDX_FAN_ONE || i == fss_pkg::IDX_FAN_TWO ||
			 i == fss_pkg::IDX_ACT_ONE || i == fss_pkg::IDX_ACT_TWO ||
			 i == fss_pkg::IDX_INT_STAT || i == fss_pkg::IDX_INT_MASK);
	endfunction

	logic       setup_rd;
	logic       acc_wr;
	logic       acc_rd;
	logic [5:0] idx;
	logic [7:0] sens_val;
	logic [7:0] fan_val [2];
	logic       summary;

	assign idx      = reg_index(paddr);
	assign setup_rd = psel && !penable && !pwrite && reg_mapped(paddr);
	assign acc_wr   = psel && penable && pwrite && reg_mapped(paddr);
	assign acc_rd   = psel && penable && !pwrite && reg_mapped(paddr);
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !reg_mapped(paddr);
	assign prdata   = st_r.rdata;
	assign irq      = |(st_r.int_stat & st_r.int_mask);
	assign ctl.mode = st_r.mode;
	assign ctl.summary_hp = summary;

	// ************************************************************
	// read views
	// ************************************************************
	always_comb begin
		sens_val = fss_pkg::RST_BYTE;
		sens_val[fss_pkg::B_LOCAL]      = 1'b1;
		sens_val[fss_pkg::B_REMOTE_ONE] = st_r.remote_det[0];
		sens_val[fss_pkg::B_REMOTE_TWO] = st_r.remote_det[1];
		for (int i = 0; i < 2; i++) begin
			fan_val[i] = fss_pkg::RST_BYTE;
			fan_val[i][fss_pkg::B_MISSING]   = st_r.s2_pres[i];
			fan_val[i][fss_pkg::B_MISSING_L] = st_r.miss_l[i];
			fan_val[i][fss_pkg::B_FAULT]     = !st_r.s2_flt[i];
			fan_val[i][fss_pkg::B_FAULT_L]   = st_r.flt_l[i];
			fan_val[i][fss_pkg::B_SLEEP]     = st_r.sleep[i];
			fan_val[i][fss_pkg::B_HP_PRIO]   = st_r.hp_prio[i];
			fan_val[i][fss_pkg::B_TACH_L]    = st_r.tach_l[i];
			fan_val[i][fss_pkg::B_HOTPLUG_L] = st_r.hot_l[i];
		end
		summary = |(st_r.miss_l | st_r.flt_l | st_r.tach_l | st_r.hot_l);
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic [7:0] wsel;
		logic [7:0] evset;
		logic       wfan;
		logic       ot_alarm;
		logic       hp_cond;
		logic       fan_in;
		logic       fan_out;
		logic       flt_edge;
		st_nxt = st_r;
		wsel   = fss_pkg::RST_BYTE;
		evset  = fss_pkg::RST_BYTE;
		wfan   = 1'b0;
		ot_alarm = 1'b0;
		hp_cond  = 1'b0;
		fan_in   = 1'b0;
		fan_out  = 1'b0;
		flt_edge = 1'b0;

		// pin synchronisers
		st_nxt.s1_pres = pins.present_n;
		st_nxt.s2_pres = st_r.s1_pres;
		st_nxt.s1_flt  = pins.fault_n;
		st_nxt.s2_flt  = st_r.s1_flt;
		st_nxt.s1_rs   = pins.remote_det;
		st_nxt.s2_rs   = st_r.s1_rs;
		st_nxt.prev_pres = st_r.s2_pres;
		st_nxt.prev_flt  = st_r.s2_flt;

		// power-up capture once the chains hold real pin levels
		if (!st_r.primed) begin
			st_nxt.prime_cnt = st_r.prime_cnt + 2'h1;
			if (st_r.prime_cnt == fss_pkg::PRIME_LAST) begin
				st_nxt.primed     = 1'b1;
				st_nxt.remote_det = st_r.s2_rs;
			end
		end

		for (int i = 0; i < 2; i++) begin
			wfan = acc_wr && (idx == fss_pkg::IDX_FAN_ONE + 6'(i));
			fan_out  = st_r.primed && st_r.s2_pres[i] && !st_r.prev_pres[i];
			fan_in   = st_r.primed && !st_r.s2_pres[i] && st_r.prev_pres[i];
			flt_edge = st_r.primed && !st_r.s2_flt[i] && st_r.prev_flt[i] && !st_r.sleep[i];

			// latched bits: zero write clears, one write keeps, event wins
			if (wfan) begin
				if (!pwdata[fss_pkg::B_MISSING_L]) st_nxt.miss_l[i] = 1'b0;
				if (!pwdata[fss_pkg::B_FAULT_L])   st_nxt.flt_l[i]  = 1'b0;
				if (!pwdata[fss_pkg::B_TACH_L])    st_nxt.tach_l[i] = 1'b0;
				if (!pwdata[fss_pkg::B_HOTPLUG_L]) st_nxt.hot_l[i]  = 1'b0;
				st_nxt.sleep[i]   = pwdata[fss_pkg::B_SLEEP];
				st_nxt.hp_prio[i] = pwdata[fss_pkg::B_HP_PRIO];
			end
			if (acc_wr && idx == fss_pkg::IDX_ACT_ONE + 6'(i))
				st_nxt.act_sleep_alarm[i] = pwdata[fss_pkg::B_ACT_SLEEP_ALARM];
			if (fan_out)
				st_nxt.miss_l[i] = 1'b1;
			if (fan_in)
				st_nxt.hot_l[i] = 1'b1;
			if (flt_edge)
				st_nxt.flt_l[i] = 1'b1;
			if (evt.tach_fault[i] && !st_r.sleep[i] && st_r.primed)
				st_nxt.tach_l[i] = 1'b1;
			if (st_r.s2_pres[i]) begin
				st_nxt.flt_l[i]  = 1'b0;
				st_nxt.tach_l[i] = 1'b0;
			end
			evset[fss_pkg::INT_RM + i]  = fan_out;
			evset[fss_pkg::INT_IN + i]  = fan_in;
			evset[fss_pkg::INT_FLT + i] = flt_edge;
			evset[fss_pkg::INT_TCH + i] = evt.tach_fault[i] && !st_r.sleep[i] &&
				st_r.primed && !st_r.s2_pres[i] && !st_r.tach_l[i];

			// speed selection; the other fan's trouble asks for hot-plug speed
			ot_alarm = evt.overtemp[i];
			hp_cond  = st_r.miss_l[1-i] || st_r.flt_l[1-i] || st_r.tach_l[1-i];
			if (st_r.sleep[i]) begin
				if (ot_alarm && st_r.act_sleep_alarm[i])
					st_nxt.mode[i] = fss_pkg::FM_ALARM;
				else
					st_nxt.mode[i] = fss_pkg::FM_STOP;
			end else if (ot_alarm && hp_cond) begin
				st_nxt.mode[i] = st_r.hp_prio[i] ? fss_pkg::FM_HOTPLUG
				                                 : fss_pkg::FM_ALARM;
			end else if (ot_alarm) begin
				st_nxt.mode[i] = fss_pkg::FM_ALARM;
			end else if (hp_cond) begin
				st_nxt.mode[i] = fss_pkg::FM_HOTPLUG;
			end else begin
				st_nxt.mode[i] = fss_pkg::FM_NORMAL;
			end
		end

		// interrupt status: read clears, new event wins
		if (acc_wr && idx == fss_pkg::IDX_INT_MASK)
			st_nxt.int_mask = pwdata[7:0];
		if (acc_rd && idx == fss_pkg::IDX_INT_STAT)
			wsel = st_r.int_stat;
		st_nxt.int_stat = (st_r.int_stat & ~wsel) | evset;

		// read data is prepared in the setup cycle
		if (setup_rd) begin
			st_nxt.rdata = fss_pkg::RST_WORD;
			unique case (idx)
				fss_pkg::IDX_SUMMARY:  st_nxt.rdata[fss_pkg::B_SUMMARY_HP] = summary;
				fss_pkg::IDX_SENSORS:  st_nxt.rdata[7:0] = sens_val;
				fss_pkg::IDX_FAN_ONE:  st_nxt.rdata[7:0] = fan_val[0];
				fss_pkg::IDX_FAN_TWO:  st_nxt.rdata[7:0] = fan_val[1];
				fss_pkg::IDX_ACT_ONE:
					st_nxt.rdata[fss_pkg::B_ACT_SLEEP_ALARM] = st_r.act_sleep_alarm[0];
				fss_pkg::IDX_ACT_TWO:
					st_nxt.rdata[fss_pkg::B_ACT_SLEEP_ALARM] = st_r.act_sleep_alarm[1];
				fss_pkg::IDX_INT_STAT: st_nxt.rdata[7:0] = st_r.int_stat;
				fss_pkg::IDX_INT_MASK: st_nxt.rdata[7:0] = st_r.int_mask;
				default:               st_nxt.rdata = fss_pkg::RST_WORD;
			endcase
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
			st_r.s1_pres   <= fss_pkg::RST_PIN_HI;
			st_r.s2_pres   <= fss_pkg::RST_PIN_HI;
			st_r.prev_pres <= fss_pkg::RST_PIN_HI;
			st_r.s1_flt    <= fss_pkg::RST_PIN_HI;
			st_r.s2_flt    <= fss_pkg::RST_PIN_HI;
			st_r.prev_flt  <= fss_pkg::RST_PIN_HI;
			st_r.mode[0]   <= fss_pkg::FM_NORMAL;
			st_r.mode[1]   <= fss_pkg::FM_NORMAL;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	property p_sensor_read;
		setup_rd && idx == fss_pkg::IDX_SENSORS |=>
			prdata[0] == 1'b1 && prdata[31:3] == 29'h0;
	endproperty
	a_sensor_read: assert property (p_sensor_read) else $error("sensor register read wrong");

	property p_remote_fixed;
		st_r.primed && $past(st_r.primed) |-> $stable(st_r.remote_det);
	endproperty
	a_remote_fixed: assert property (p_remote_fixed) else $error("remote detect changed");

	property p_missing_live;
		setup_rd && idx == fss_pkg::IDX_FAN_ONE |=>
			prdata[0] == $past(st_r.s2_pres[0]) && prdata[2] == !$past(st_r.s2_flt[0]);
	endproperty
	a_missing_live: assert property (p_missing_live) else $error("live fan bits wrong");

	property p_removal_latch;
		st_r.primed && st_r.s2_pres[1] && !st_r.prev_pres[1] |=> st_r.miss_l[1] && st_r.int_stat[1];
	endproperty
	a_removal_latch: assert property (p_removal_latch) else $error("removal not latched");

	property p_fault_clear_absent;
		st_r.s2_pres[0] |=> !st_r.flt_l[0] && !st_r.tach_l[0];
	endproperty
	a_fault_clear_absent: assert property (p_fault_clear_absent) else $error("latch kept on absent fan");

	property p_sleep_stop;
		st_r.sleep[0] && !(evt.overtemp[0] && st_r.act_sleep_alarm[0]) |=>
			st_r.mode[0] == fss_pkg::FM_STOP;
	endproperty
	a_sleep_stop: assert property (p_sleep_stop) else $error("sleeping fan not stopped");

	property p_prio;
		!st_r.sleep[1] && evt.overtemp[1] && st_r.miss_l[0] |=>
			st_r.mode[1] == ($past(st_r.hp_prio[1]) ? fss_pkg::FM_HOTPLUG : fss_pkg::FM_ALARM);
	endproperty
	a_prio: assert property (p_prio) else $error("speed priority wrong");

	property p_tach_latch;
		st_r.primed && evt.tach_fault[0] && !st_r.sleep[0] && !st_r.s2_pres[0] ##1
			(!(acc_wr && idx == fss_pkg::IDX_FAN_ONE) && !st_r.s2_pres[0]) [*2]
			|-> st_r.tach_l[0];
	endproperty
	a_tach_latch: assert property (p_tach_latch) else $error("tach fault lost");

	property p_insert_latch;
		st_r.primed && !st_r.s2_pres[0] && st_r.prev_pres[0] |=> st_r.hot_l[0];
	endproperty
	a_insert_latch: assert property (p_insert_latch) else $error("insertion not latched");

	property p_write_one_keeps;
		acc_wr && idx == fss_pkg::IDX_FAN_ONE && pwdata[7] && st_r.hot_l[0] |=> st_r.hot_l[0];
	endproperty
	a_write_one_keeps: assert property (p_write_one_keeps) else $error("one write cleared latch");

	property p_summary;
		setup_rd && idx == fss_pkg::IDX_SUMMARY |=>
			prdata[6] == $past(|(st_r.miss_l | st_r.flt_l | st_r.tach_l | st_r.hot_l));
	endproperty
	a_summary: assert property (p_summary) else $error("summary bit wrong");

	property p_fan_two_live;
		setup_rd && idx == fss_pkg::IDX_FAN_TWO |=>
			prdata[0] == $past(st_r.s2_pres[1]) && prdata[2] == !$past(st_r.s2_flt[1]);
	endproperty
	a_fan_two_live: assert property (p_fan_two_live) else $error("fan two live bits wrong");

	property p_fault_edge;
		st_r.primed && !st_r.s2_flt[0] && st_r.prev_flt[0] && !st_r.sleep[0] &&
			!st_r.s2_pres[0] |=> st_r.flt_l[0];
	endproperty
	a_fault_edge: assert property (p_fault_edge) else $error("fault edge not latched");

	property p_sleep_no_fault;
		st_r.sleep[0] && !st_r.flt_l[0] |=>
			!st_r.flt_l[0];
	endproperty
	a_sleep_no_fault: assert property (p_sleep_no_fault) else $error("sleeping fan latched fault");

	property p_sleep_alarm;
		st_r.sleep[1] && evt.overtemp[1] && st_r.act_sleep_alarm[1] |=>
			st_r.mode[1] == fss_pkg::FM_ALARM;
	endproperty
	a_sleep_alarm: assert property (p_sleep_alarm) else $error("sleeping fan not at alarm");

	property p_normal_speed;
		st_r.hot_l[0] && !st_r.sleep[0] && !evt.overtemp[0] && !st_r.miss_l[1] &&
			!st_r.flt_l[1] && !st_r.tach_l[1] |=> st_r.mode[0] == fss_pkg::FM_NORMAL;
	endproperty
	a_normal_speed: assert property (p_normal_speed) else $error("inserted fan not normal");

	property p_zero_write_clears;
		acc_wr && idx == fss_pkg::IDX_FAN_TWO && !pwdata[1] &&
			!(st_r.primed && st_r.s2_pres[1] && !st_r.prev_pres[1]) |=> !st_r.miss_l[1];
	endproperty
	a_zero_write_clears: assert property (p_zero_write_clears) else $error("zero write kept latch");

endmodule

`default_nettype wire

//--- fss_fan_model.sv
/*
 * Two fans and the remote sensor detect levels, as seen by the status bank.
 * Assumes the bench sets fitted, broken and sensors; pins move just after an edge.
 */
`timescale 1ns/10ps
`default_nettype none

module fss_fan_model (
	// clock
	input  wire logic          sys_clk,
	// fan state from the bench
	input  wire logic [1:0]    fitted,
	input  wire logic [1:0]    broken,
	input  wire logic [1:0]    sensors,
	// pins toward the device
	output var fss_pkg::fss_pins_t pins
);
	// ************************************************************
	// pins: low presence means fitted, low fault means broken
	// ************************************************************
	initial pins = '{present_n: 2'h3, fault_n: 2'h3, remote_det: 2'h0};
	always @(posedge sys_clk) begin
		pins.present_n <= ~fitted;
		pins.fault_n <= ~broken;
		pins.remote_det <= sensors;
	end
endmodule

`default_nettype wire

//--- testbench.sv
/*
 * Self-checking bench for the fan and sensor status bank over APB.
 * Assumes fss_pkg, fss_status_regs and fss_fan_model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic                sys_clk;
	logic                nrst;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic                pready;
	logic                pslverr;
	logic                irq;
	logic                err_v;
	logic [7:0]          paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic [31:0]         rd_v;
	logic [1:0]          fitted;
	logic [1:0]          broken;
	logic [1:0]          sensors;
	fss_pkg::fss_pins_t  pins;
	fss_pkg::fss_evt_t   evt;
	fss_pkg::fss_ctl_t   ctl;
	int                  bad_count;
	int                  n_compared;

	initial sys_clk = 1'b0;
	always #50 sys_clk = ~sys_clk;

	fss_status_regs u_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .pins(pins), .evt(evt), .ctl(ctl), .irq(irq));
	fss_fan_model u_fans (.sys_clk(sys_clk), .fitted(fitted), .broken(broken),
		.sensors(sensors), .pins(pins));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic give_verdict();
		$display("counts: %0d compared, %0d mismatched", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			give_verdict();
		end
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input string what);
		apb({idx, 2'h0}, 1'b0, 32'h0);
		check(what, rd_v, {24'h0, exp});
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		apb({idx, 2'h0}, 1'b1, {24'h0, d});
	endtask

	task automatic settle();
		repeat (8) @(posedge sys_clk);
	endtask

	task automatic mode_is(input int f, input fss_pkg::fss_mode_t m, input string what);
		repeat (2) @(posedge sys_clk);
		check(what, {28'h0, ctl.mode[f]}, {28'h0, m});
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		evt = '0;
		fitted = 2'h1;
		broken = 2'h0;
		sensors = 2'h1;
		bad_count = 0;
		n_compared = 0;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		settle();
		rd(fss_pkg::IDX_SENSORS, 8'h03, "sensors");
		wr(fss_pkg::IDX_SENSORS, 8'hff);
		rd(fss_pkg::IDX_SENSORS, 8'h03, "sensors ro");
		rd(fss_pkg::IDX_FAN_ONE, 8'h00, "fan1 reset");
		rd(fss_pkg::IDX_FAN_TWO, 8'h01, "fan2 reset");
		$display("test reset values done");
		wr(fss_pkg::IDX_INT_MASK, 8'h01);
		fitted <= 2'h3;
		settle();
		rd(fss_pkg::IDX_FAN_TWO, 8'h80, "fan2 insert");
		rd(fss_pkg::IDX_SUMMARY, 8'h40, "summary set");
		check("summary pin set", {31'h0, ctl.summary_hp}, 32'h1);
		wr(fss_pkg::IDX_FAN_TWO, 8'h00);
		rd(fss_pkg::IDX_SUMMARY, 8'h00, "summary clear");
		check("summary pin clear", {31'h0, ctl.summary_hp}, 32'h0);
		apb({fss_pkg::IDX_INT_STAT, 2'h0}, 1'b0, 32'h0);
		fitted <= 2'h2;
		settle();
		check("irq on", {31'h0, irq}, 32'h1);
		rd(fss_pkg::IDX_FAN_ONE, 8'h03, "fan1 removed");
		wr(fss_pkg::IDX_FAN_ONE, 8'hff);
		rd(fss_pkg::IDX_FAN_ONE, 8'h33, "write one keeps");
		wr(fss_pkg::IDX_FAN_ONE, 8'h00);
		rd(fss_pkg::IDX_FAN_ONE, 8'h01, "write zero clears");
		rd(fss_pkg::IDX_INT_STAT, 8'h01, "int status");
		check("irq off", {31'h0, irq}, 32'h0);
		fitted <= 2'h3;
		settle();
		rd(fss_pkg::IDX_FAN_ONE, 8'h80, "fan1 refit");
		wr(fss_pkg::IDX_FAN_ONE, 8'h00);
		$display("test hot-plug latches done");
		broken <= 2'h1;
		evt.tach_fault <= 2'h1;
		@(posedge sys_clk);
		evt.tach_fault <= 2'h0;
		settle();
		rd(fss_pkg::IDX_FAN_ONE, 8'h4c, "fault and tach");
		broken <= 2'h0;
		settle();
		rd(fss_pkg::IDX_FAN_ONE, 8'h48, "fault gone");
		wr(fss_pkg::IDX_FAN_ONE, 8'h82);
		rd(fss_pkg::IDX_FAN_ONE, 8'h00, "fault clear");
		broken <= 2'h1;
		evt.tach_fault <= 2'h1;
		@(posedge sys_clk);
		evt.tach_fault <= 2'h0;
		settle();
		fitted <= 2'h2;
		settle();
		rd(fss_pkg::IDX_FAN_ONE, 8'h07, "absent clears");
		broken <= 2'h0;
		fitted <= 2'h3;
		settle();
		wr(fss_pkg::IDX_FAN_ONE, 8'h00);
		mode_is(0, fss_pkg::FM_NORMAL, "fan1 normal");
		mode_is(1, fss_pkg::FM_NORMAL, "fan2 normal");
		$display("test fault latches done");
		wr(fss_pkg::IDX_FAN_TWO, 8'h10);
		mode_is(1, fss_pkg::FM_STOP, "sleep stop");
		broken <= 2'h2;
		settle();
		rd(fss_pkg::IDX_FAN_TWO, 8'h14, "sleep no latch");
		broken <= 2'h0;
		evt.overtemp <= 2'h2;
		mode_is(1, fss_pkg::FM_STOP, "sleep overtemp");
		wr(fss_pkg::IDX_ACT_TWO, 8'h10);
		mode_is(1, fss_pkg::FM_ALARM, "sleep alarm");
		wr(fss_pkg::IDX_FAN_TWO, 8'h00);
		fitted <= 2'h2;
		settle();
		mode_is(1, fss_pkg::FM_ALARM, "prio alarm");
		wr(fss_pkg::IDX_FAN_TWO, 8'h20);
		mode_is(1, fss_pkg::FM_HOTPLUG, "prio hot-plug");
		$display("test speed modes done");
		apb(8'h3c, 1'b0, 32'h0);
		check("unmapped error", {31'h0, err_v}, 32'h1);
		$display("test unmapped done");
		sensors <= 2'h2;
		settle();
		rd(fss_pkg::IDX_SENSORS, 8'h03, "sensors fixed");
		nrst <= 1'b0;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		settle();
		check("irq reset", {31'h0, irq}, 32'h0);
		rd(fss_pkg::IDX_SENSORS, 8'h05, "sensors redetect");
		rd(fss_pkg::IDX_FAN_ONE, 8'h01, "fan1 reset absent");
		rd(fss_pkg::IDX_FAN_TWO, 8'h00, "fan2 reset fitted");
		$display("test second reset done");
		give_verdict();
	end

	initial begin
		repeat (5000) @(posedge sys_clk);
		$display("ERROR run limit expected finish seen hang");
		bad_count++;
		give_verdict();
	end
endmodule

`default_nettype wire
